//--- ttw_ctrl_model.sv
/* ttw_ctrl_model: tape controller side facing the codec.
   Assumes bench requests come one cycle ahead of the pulses. */
`timescale 1ns/1ps
module ttw_ctrl_model
    import ttw_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // levels and pulse requests from the bench
    input wire ttw_wr_in_t wl,
    input wire ttw_rd_in_t rl,
    input wire logic dr_q,
    input wire logic lrc_q,
    input wire logic pk_q,
    // lines towards the codec
    output ttw_wr_in_t wr_in,
    output ttw_rd_in_t rd_in
);
    // one-cycle pulses; data scrambled outside its strobe
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_in <= '0;
            rd_in <= '0;
            wr_in.write_gate_n <= 1'b1;
        end
        else
        begin
            wr_in <= wl;
            wr_in.data_ready <= dr_q;
            wr_in.lrc_strobe <= lrc_q;
            wr_in.write_parity_data_in <= dr_q ? wl.write_parity_data_in
                : ~wl.write_parity_data_in;
            rd_in <= rl;
            rd_in.read_peak <= pk_q ? rl.read_peak : 9'h000;
        end
    end
endmodule

//--- ttw_pkg.sv
/*
 * ttw_pkg: constants and types for the tape track write/read block.
 * Assumes a 100 MHz system clock and an APB master with 32-bit data.
 */
package ttw_pkg;

    // clock
    localparam int CLK_PERIOD_NS = 10;

    // track layout
    localparam int NTRK = 9;
    localparam logic [8:0] SEVEN_TRK_MASK = 9'h1fc; // tracks 0 and 1 unused

    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;

    // control field positions
    localparam int CTRL_PE_MODE = 0;
    localparam int CTRL_SEVEN_TRACK = 1;
    localparam int CTRL_SINGLE_GAP = 2;
    localparam int CTRL_SPEED_SEL = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // status field positions
    localparam int STS_RFF_LSB = 0;
    localparam int STS_WFF_LSB = 9;
    localparam int STS_PFF_LSB = 18;
    localparam int STS_BOOST = 27;
    localparam int STS_DESKEW = 28;
    localparam int STS_STROBE = 29;
    localparam int STS_THR_LOW = 30;

    // timing: deskew is half a data bit period, shortened in fast cases
    localparam int DESKEW_NOM_NS = 12500;
    localparam int DESKEW_SHORT_NS = 6250;
    localparam int DESKEW_NOM_CYC = DESKEW_NOM_NS / CLK_PERIOD_NS;
    localparam int DESKEW_SHORT_CYC = DESKEW_SHORT_NS / CLK_PERIOD_NS;
    // read strobe pulse, printed as 1 second
    localparam int STROBE_TIME_MS = 1000;
    localparam int STROBE_CYC = STROBE_TIME_MS * (1000000 / CLK_PERIOD_NS);
    localparam int CNT_W = 27;

    // read slicing levels in percent of maximum amplitude
    localparam int THR_NORMAL_PCT = 25;
    localparam int THR_LOW_PCT = 12;

    // strobe timing chain states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DESKEW = 3'b010,
        ST_STROBE = 3'b100
    } ttw_st_t;

    // controller-side write inputs
    typedef struct packed {
        logic data_ready;
        logic [8:0] write_parity_data_in;
        logic lrc_strobe;
        logic write_gate_n;
        logic write_power;
        logic pe_write_gate;
    } ttw_wr_in_t;

    // controller-side read inputs
    typedef struct packed {
        logic motion;
        logic read_after_write;
        logic high_density_sel;
        logic read_threshold1;
        logic read_threshold2;
        logic [8:0] read_peak;
    } ttw_rd_in_t;

    // head-side outputs
    typedef struct packed {
        logic [8:0] head_drive_a;
        logic [8:0] head_drive_b;
        logic write_current_en;
        logic erase_en;
        logic boost_current_flag;
        logic envelope_supply_en;
        logic thr_low_sel;
    } ttw_head_t;

    // controller-side read and format outputs
    typedef struct packed {
        logic [8:0] read_parity_data_out;
        logic read_data_strobe;
        logic deskew_delay_trigger;
        logic nrzi_format;
        logic seven_track_ind;
        logic single_gap_ind;
        logic speed_ind;
    } ttw_rd_out_t;

endpackage

//--- ttw_track_codec.sv
/*
 * ttw_track_codec: nine-track NRZI/PE write and NRZI read logic with an
 * APB slave for configuration and status.
 * Assumes all inputs synchronous to mclk; read peaks come as one-cycle
 * pulses from the analog detector, data_ready as a one-cycle pulse.
 */
// Function
// [R1] NRZI: data ready with a one on a track toggles its write flip-flop.
// [R2] each write flip-flop change swaps the active head driver of the pair.
// [R3] longitudinal check strobe clears any set write flip-flop.
// [R4] nine track channels; seven-track mode leaves tracks 0 and 1 unused.
// [R5] NRZI write and erase current only with write gate low and write power.
// [R6] read slicing level defaults to about 25 percent.
// [R7] a reduced slicing level of about 12 percent is available.
// [R8] threshold select one applies the high slicing level.
// [R9] threshold select two applies the low slicing level.
// [R10] peaks set read flip-flops; output only with motion and read strobe.
// [R11] any read detection starts a deskew delay of half a bit period; the code starts it only on a peak in NRZI with the chain idle.
// [R12] deskew is shortened for read-after-write and high density reads.
// [R13] after deskew a long strobe pulse, gated by motion, is the read strobe.
// [R14] the end of the read strobe clears all read flip-flops.
// [R15] configuration picks seven-track, single-gap, speed; NRZI always shown.
// [R16] PE path has one write/read channel per track, nine in all; the code has the nine PE write channels only, no PE read.
// [R17] PE: inverted data captured on data ready; complements drive heads.
// [R18] entering PE write sets the boost current flag.
// [R19] first data ready in PE write clears the boost current flag.
// [R20] PE path energizes the erase head ahead of any write.
// [R21] tape motion enables envelope power for PE read circuits.
// [R22] reset clears write, read and boost state; strobe chain idle.
`timescale 1ns/1ps

module ttw_track_codec
    import ttw_pkg::*;
#(
    parameter int STROBE_CYCLES = STROBE_CYC
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // controller side
    input wire ttw_wr_in_t wr_in,
    input wire ttw_rd_in_t rd_in,
    output ttw_rd_out_t rd_out,
    // head side
    output ttw_head_t head
);

    // whole module state
    typedef struct packed {
        logic [3:0] cfg;
        logic [8:0] wff;
        logic [8:0] pff;
        logic boost;
        logic pe_gate_d;
        logic [8:0] rff;
        ttw_st_t st;
        logic [CNT_W-1:0] cnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        ttw_head_t head;
        ttw_rd_out_t rd_out;
    } ttw_state_t;

    ttw_state_t s_r;
    ttw_state_t s_nxt;

    // active track mask for the current head configuration
    function automatic logic [8:0] trk_mask(input logic [3:0] cfg);
        logic [8:0] m;
        m = 9'h1ff;
        if (cfg[CTRL_SEVEN_TRACK] && !cfg[CTRL_PE_MODE])
        begin
            m = SEVEN_TRK_MASK; // [R4]
        end
        return m;
    endfunction

    // status word assembly
    function automatic logic [31:0] status_word(input ttw_state_t s);
        logic [31:0] w;
        w = 32'h0;
        w[STS_RFF_LSB +: NTRK] = s.rff;
        w[STS_WFF_LSB +: NTRK] = s.wff;
        w[STS_PFF_LSB +: NTRK] = s.pff;
        w[STS_BOOST] = s.boost;
        w[STS_DESKEW] = (s.st == ST_DESKEW);
        w[STS_STROBE] = (s.st == ST_STROBE);
        w[STS_THR_LOW] = s.head.thr_low_sel;
        return w;
    endfunction

    localparam logic [CNT_W-1:0] DSK_NOM = CNT_W'(DESKEW_NOM_CYC - 1);
    localparam logic [CNT_W-1:0] DSK_SHORT = CNT_W'(DESKEW_SHORT_CYC - 1);
    localparam logic [CNT_W-1:0] STB_LEN = CNT_W'(STROBE_CYCLES - 1);

    logic [8:0] mask;
    logic pe;
    logic dr_write;
    logic [8:0] wff_v;
    logic [8:0] pff_v;
    logic [8:0] rff_v;
    logic setup;
    logic hit_ctrl;
    logic hit_sts;
    logic strobe_end;

    // next-state logic
    always_comb
    begin
        s_nxt = s_r;
        mask = trk_mask(s_r.cfg);
        pe = s_r.cfg[CTRL_PE_MODE];
        setup = psel && !penable;
        hit_ctrl = (paddr == OFS_CTRL);
        hit_sts = (paddr == OFS_STATUS);
        strobe_end = 1'b0;

        // apb: decode at setup, zero-wait answer in the access cycle
        s_nxt.pready = setup;
        s_nxt.pslverr = 1'b0; // error flag stands only with pready
        if (setup)
        begin
            s_nxt.pslverr = !(hit_ctrl || hit_sts);
            s_nxt.prdata = 32'h0;
            if (!pwrite && hit_ctrl)
            begin
                s_nxt.prdata = {28'h0, s_r.cfg};
            end
            else if (!pwrite && hit_sts)
            begin
                s_nxt.prdata = status_word(s_r);
            end
        end
        if (psel && penable && s_r.pready && pwrite && hit_ctrl && pstrb[0])
        begin
            s_nxt.cfg = pwdata[3:0]; // [R15]
        end

        // nrzi write toggles, check strobe clears
        wff_v = s_r.wff;
        dr_write = wr_in.data_ready && !pe;
        if (dr_write)
        begin
            wff_v = wff_v ^ (wr_in.write_parity_data_in & mask); // [R1] [R4]
        end
        if (wr_in.lrc_strobe && !pe)
        begin
            wff_v = 9'h0; // [R3]
        end
        s_nxt.wff = wff_v;

        // pe write captures inverted data on every track
        pff_v = s_r.pff;
        if (wr_in.data_ready && pe)
        begin
            pff_v = ~wr_in.write_parity_data_in; // [R16] [R17]
        end
        s_nxt.pff = pff_v;

        // boost current: first data ready clears, entry sets and wins
        s_nxt.pe_gate_d = wr_in.pe_write_gate;
        if (pe && wr_in.pe_write_gate && wr_in.data_ready)
        begin
            s_nxt.boost = 1'b0; // [R19]
        end
        if (pe && wr_in.pe_write_gate && !s_r.pe_gate_d)
        begin
            s_nxt.boost = 1'b1; // [R18]
        end
        if (!wr_in.pe_write_gate)
        begin
            s_nxt.boost = 1'b0;
        end

        // head drivers: complementary pair follows the track flip-flop
        if (pe)
        begin
            s_nxt.head.head_drive_a = pff_v; // [R17]
            s_nxt.head.head_drive_b = ~pff_v;
            s_nxt.head.write_current_en = wr_in.pe_write_gate
                && wr_in.write_power;
            s_nxt.head.erase_en = wr_in.pe_write_gate; // [R20]
        end
        else
        begin
            s_nxt.head.head_drive_a = wff_v & mask; // [R2]
            s_nxt.head.head_drive_b = ~wff_v & mask; // [R2]
            s_nxt.head.write_current_en = !wr_in.write_gate_n
                && wr_in.write_power; // [R5]
            s_nxt.head.erase_en = !wr_in.write_gate_n
                && wr_in.write_power; // [R5]
        end
        s_nxt.head.boost_current_flag = s_nxt.boost;
        s_nxt.head.envelope_supply_en = pe && rd_in.motion; // [R21]

        // read slicing level: normal unless select two asks for low with select one clear
        if (rd_in.read_threshold1)
        begin
            s_nxt.head.thr_low_sel = 1'b0; // [R6] [R8]
        end
        else if (rd_in.read_threshold2)
        begin
            s_nxt.head.thr_low_sel = 1'b1; // [R7] [R9]
        end
        else
        begin
            s_nxt.head.thr_low_sel = 1'b0; // [R6]
        end

        // strobe timing chain
        case (s_r.st)
            ST_IDLE:
            begin
                if (!pe && |(rd_in.read_peak & mask))
                begin
                    s_nxt.st = ST_DESKEW; // [R11]
                    if (rd_in.read_after_write || rd_in.high_density_sel)
                    begin
                        s_nxt.cnt = DSK_SHORT; // [R12]
                    end
                    else
                    begin
                        s_nxt.cnt = DSK_NOM; // [R11]
                    end
                end
            end
            ST_DESKEW:
            begin
                if (s_r.cnt == '0)
                begin
                    s_nxt.st = ST_STROBE; // [R13]
                    s_nxt.cnt = STB_LEN;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            ST_STROBE:
            begin
                if (s_r.cnt == '0)
                begin
                    s_nxt.st = ST_IDLE;
                    strobe_end = 1'b1;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            default:
            begin
                s_nxt.st = ST_IDLE;
                s_nxt.cnt = '0;
            end
        endcase

        // read flip-flops: end of strobe clears, a new peak wins
        rff_v = s_r.rff;
        if (strobe_end)
        begin
            rff_v = 9'h0; // [R14]
        end
        if (!pe)
        begin
            rff_v = rff_v | (rd_in.read_peak & mask); // [R10]
        end
        s_nxt.rff = rff_v;

        // controller outputs
        s_nxt.rd_out.read_data_strobe = (s_nxt.st == ST_STROBE)
            && rd_in.motion; // [R13]
        s_nxt.rd_out.read_parity_data_out = s_nxt.rd_out.read_data_strobe
            ? rff_v : 9'h0; // [R10]
        s_nxt.rd_out.deskew_delay_trigger = (s_nxt.st == ST_DESKEW);
        s_nxt.rd_out.nrzi_format = 1'b1; // [R15]
        s_nxt.rd_out.seven_track_ind = s_nxt.cfg[CTRL_SEVEN_TRACK];
        s_nxt.rd_out.single_gap_ind = s_nxt.cfg[CTRL_SINGLE_GAP];
        s_nxt.rd_out.speed_ind = s_nxt.cfg[CTRL_SPEED_SEL];
    end

    // state register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0; // [R22]
            s_r.cfg <= CTRL_RESET;
            s_r.st <= ST_IDLE; // [R22]
            s_r.rd_out.nrzi_format <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign head = s_r.head;
    assign rd_out = s_r.rd_out;

endmodule

//--- ttw_track_codec_asserts.sv
/* ttw_track_codec_asserts: port timing checks for the track codec.
   Assumes it is bound onto ttw_track_codec with its strobe length. */
`timescale 1ns/1ps
module ttw_checker
    import ttw_pkg::*;
#(
    parameter int STROBE_CYCLES = 20
)
(
    // clock, reset and apb
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // controller and head side
    input wire ttw_wr_in_t wr_in,
    input wire ttw_rd_in_t rd_in,
    input wire ttw_rd_out_t rd_out,
    input wire ttw_head_t head
);
    logic [3:0] ctrl_r;
    logic [8:0] msk;
    int st_cnt;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // shadow of the control word and a strobe length counter
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= 4'h0;
            st_cnt <= 0;
        end
        else
        begin
            if (psel && penable && pready && pwrite && paddr == OFS_CTRL)
                ctrl_r <= pstrb[0] ? pwdata[3:0] : ctrl_r;
            st_cnt <= rd_out.read_data_strobe ? st_cnt + 1 : 0;
        end
    end
    // tracks 0 and 1 stay quiet in seven-track mode
    assign msk = ctrl_r[1] ? SEVEN_TRK_MASK : 9'h1ff;

    // a peak seen while the strobe chain rests
    sequence s_idle;
        !rd_out.deskew_delay_trigger && !rd_out.read_data_strobe
            && rd_in.motion && !ctrl_r[0];
    endsequence
    sequence s_peak;
        rd_in.read_peak != 9'h000;
    endsequence

    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no apb answer after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    wr_toggle_a: assert property (!ctrl_r[0] && wr_in.data_ready
        && !wr_in.lrc_strobe |=> head.head_drive_a == (msk
        & ($past(head.head_drive_a) ^ $past(wr_in.write_parity_data_in))))
        else $error("nrzi write toggle wrong");
    lrc_clear_a: assert property (!ctrl_r[0] && wr_in.lrc_strobe
        |=> head.head_drive_a == 9'h000)
        else $error("check strobe left a track set");
    pe_capture_a: assert property (ctrl_r[0] && wr_in.data_ready
        |=> head.head_drive_a == ~$past(wr_in.write_parity_data_in)
        && head.head_drive_b == ~head.head_drive_a)
        else $error("pe capture wrong");
    wr_current_a: assert property (!ctrl_r[0] |=> head.write_current_en
        == (!$past(wr_in.write_gate_n) && $past(wr_in.write_power)))
        else $error("nrzi write current wrong");
    boost_set_a: assert property (ctrl_r[0]
        && $rose(wr_in.pe_write_gate) |=> head.boost_current_flag)
        else $error("boost not set on pe write");
    boost_clear_a: assert property (ctrl_r[0] && wr_in.data_ready
        && wr_in.pe_write_gate && $past(wr_in.pe_write_gate)
        |=> !head.boost_current_flag)
        else $error("boost not cleared by data ready");
    deskew_start_a: assert property (s_idle ##0 s_peak
        |=> rd_out.deskew_delay_trigger [*8])
        else $error("peak did not start deskew");
    strobe_len_a: assert property (st_cnt <= STROBE_CYCLES)
        else $error("read strobe too long");
    read_gate_a: assert property (!rd_out.read_data_strobe
        |-> rd_out.read_parity_data_out == 9'h000)
        else $error("read data shown without strobe");
    thr_pick_a: assert property (rd_in.read_threshold1
        || rd_in.read_threshold2
        |=> head.thr_low_sel == !$past(rd_in.read_threshold1))
        else $error("slicing level choice wrong");
endmodule

bind ttw_track_codec ttw_checker #(.STROBE_CYCLES(STROBE_CYCLES)) chk_u (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wr_in(wr_in),
    .rd_in(rd_in), .rd_out(rd_out), .head(head));

//--- ttw_track_codec_bench.sv
/* ttw_track_codec_bench: self-checking bench for the track codec.
   Assumes the controller model and the bound checker beside it. */
`timescale 1ns/1ps
module ttw_track_codec_bench
    import ttw_pkg::*;
;
    localparam int STB = 20;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, ev;
    logic dr_q, lrc_q, pk_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [3:0] pstrb;
    ttw_wr_in_t wl, wr_in;
    ttw_rd_in_t rl, rd_in;
    ttw_rd_out_t rd_out;
    ttw_head_t head;
    int bad_count, total_checks;
    int cyc = 0;

    ttw_track_codec #(.STROBE_CYCLES(STB)) dut_u (.mclk(mclk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wr_in(wr_in), .rd_in(rd_in), .rd_out(rd_out),
        .head(head));
    ttw_ctrl_model ctl_u (.mclk(mclk), .rst_n(rst_n), .wl(wl), .rl(rl),
        .dr_q(dr_q), .lrc_q(lrc_q), .pk_q(pk_q), .wr_in(wr_in), .rd_in(rd_in));

    // clock and hang guard
    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            test_done;
        end
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // one apb transfer; read data and error land in rv and ev
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // data ready pulse with data, or a check strobe alone
    task dr(input logic [8:0] d, input logic l);
        @(posedge mclk);
        wl.write_parity_data_in <= d;
        dr_q <= !l;
        lrc_q <= l;
        @(posedge mclk);
        dr_q <= 1'b0;
        lrc_q <= 1'b0;
    endtask

    task t_regs;
        chk(rd_out.nrzi_format, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rv, 32'h0);
        apb(1'b1, OFS_CTRL, 32'he);
        apb(1'b1, OFS_STATUS, 32'hffffffff);
        tick(2);
        chk({rd_out.seven_track_ind, rd_out.single_gap_ind,
            rd_out.speed_ind}, 3'h7);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rv, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rv, 32'h0);
        chk({31'h0, ev}, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h0);
    endtask
    task t_nrzi;
        tick(1);
        chk(head.write_current_en, 1'b0);
        wl.write_gate_n <= 1'b0;
        tick(3);
        chk({head.write_current_en, head.erase_en}, 2'h3);
        dr(9'h0a5, 1'b0);
        tick(2);
        chk({head.head_drive_a, head.head_drive_b}, 18'h14b5a);
        dr(9'h0ff, 1'b0);
        tick(2);
        chk(head.head_drive_a, 9'h05a);
        dr(9'h000, 1'b1);
        tick(2);
        chk(head.head_drive_a, 9'h000);
        apb(1'b1, OFS_CTRL, 32'h2);
        dr(9'h1ff, 1'b0);
        tick(2);
        chk({head.head_drive_a, head.head_drive_b}, 18'h3f800);
        dr(9'h000, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h0);
        wl.write_gate_n <= 1'b1;
    endtask
    task t_thr;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            rl.read_threshold1 <= i[1];
            rl.read_threshold2 <= i[0];
            tick(3);
            chk(head.thr_low_sel, i == 1);
        end
        rl.read_threshold1 <= 1'b0;
        rl.read_threshold2 <= 1'b0;
    endtask
    task t_read(input logic [1:0] fast, input int n);
        int k;
        @(posedge mclk);
        rl.high_density_sel <= fast[0];
        rl.read_after_write <= fast[1];
        rl.read_peak <= 9'h041;
        pk_q <= 1'b1;
        @(posedge mclk);
        pk_q <= 1'b0;
        while (rd_out.deskew_delay_trigger !== 1'b1) @(posedge mclk);
        for (k = 0; rd_out.deskew_delay_trigger === 1'b1; k++)
            @(posedge mclk);
        chk(k, n);
        chk({rd_out.read_data_strobe, rd_out.read_parity_data_out},
            10'h241);
        for (k = 0; rd_out.read_data_strobe === 1'b1; k++) @(posedge mclk);
        chk(k, STB);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rv[8:0], 9'h000);
        rl.high_density_sel <= 1'b0;
        rl.read_after_write <= 1'b0;
    endtask
    task t_pe;
        apb(1'b1, OFS_CTRL, 32'h1);
        wl.pe_write_gate <= 1'b1;
        tick(3);
        chk(head.boost_current_flag, 1'b1);
        chk({head.erase_en, head.write_current_en}, 2'h3);
        chk(head.envelope_supply_en, 1'b1);
        dr(9'h0f0, 1'b0);
        tick(2);
        chk({head.head_drive_a, head.head_drive_b}, 18'h21ef0);
        chk(head.boost_current_flag, 1'b0);
        wl.pe_write_gate <= 1'b0;
    endtask
    task test_done;
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, dr_q, lrc_q, pk_q} = 6'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        wl = '0;
        rl = '0;
        wl.write_gate_n = 1'b1;
        wl.write_power = 1'b1;
        rl.motion = 1'b1;
        bad_count = 0;
        total_checks = 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs;
        t_nrzi;
        t_thr;
        t_read(2'b00, DESKEW_NOM_CYC);
        t_read(2'b01, DESKEW_SHORT_CYC);
        t_read(2'b10, DESKEW_SHORT_CYC);
        t_pe;
        test_done;
    end
endmodule
